/* rtl/icu_pkg.sv */
// Purpose: Shared constants for the integer compare unit and its issuing end.
// Assumes: 32-bit instruction words and 32 general-purpose registers.
// Notes:   Field positions and opcodes are held here once.
package icu_pkg;
   localparam int unsigned ICU_WORD_W      = 32;
   localparam int unsigned ICU_IDX_W       = 5;
   localparam int unsigned ICU_IMM_W       = 16;
   localparam int unsigned ICU_NREGS       = 32;
   localparam int unsigned ICU_A_LSB       = 27;
   localparam int unsigned ICU_B_LSB       = 22;
   localparam int unsigned ICU_C_LSB       = 17;
   localparam int unsigned ICU_XOP_LSB     = 11;
   localparam int unsigned ICU_IMM_LSB     = 6;
   localparam int unsigned ICU_OP_LSB      = 0;
   localparam int unsigned ICU_OP_W        = 6;
   localparam logic [5:0]  ICU_OP_RTYPE    = 6'h3A;
   localparam logic [5:0]  ICU_OP_CMPEQI   = 6'h20;
   localparam logic [5:0]  ICU_OP_CMPGEI   = 6'h08;
   localparam logic [5:0]  ICU_OP_CMPGEUI  = 6'h28;
   localparam logic [5:0]  ICU_XOP_CMPEQ   = 6'h20;
   localparam logic [5:0]  ICU_XOP_CMPGE   = 6'h08;
   localparam logic [5:0]  ICU_XOP_CMPGEU  = 6'h28;
   localparam logic [31:0] ICU_WORD_RESET  = 32'h0000_0000;
   localparam logic [4:0]  ICU_ZERO_REG    = 5'h00;
   localparam logic [15:0] ICU_ZEXT_UPPER  = 16'h0000;
   localparam int unsigned ICU_LATENCY     = 1;
endpackage

/* rtl/icu_if.sv */
// Purpose: Link between the decode/register-file end and the compare unit.
// Assumes: One clock; operands arrive together with the instruction word.
// Notes:   Issue is a one-cycle pulse; result returns one cycle later.
`timescale 1ns/1ps
interface icu_if;
   import icu_pkg::*;
   logic                  issue;
   logic [31:0]           instr;
   logic [31:0]           src_a;
   logic [31:0]           src_b;
   logic                  wr_en;
   logic [4:0]            wr_idx;
   logic [31:0]           wr_data;
   logic                  illegal;
   modport unit (input issue, input instr, input src_a, input src_b,
                 output wr_en, output wr_idx, output wr_data, output illegal);
   modport issuer (output issue, output instr, output src_a, output src_b,
                   input wr_en, input wr_idx, input wr_data, input illegal);
endinterface

/* rtl/icu_issuer.sv */
// Purpose: Issuing end: encodes compares, reads and writes the register file.
// Assumes: One request at a time; req is accepted only when ready is high.
// Notes:   Greater-than and less-or-equal forms are built by swapping or +1.
`timescale 1ns/1ps
module icu_issuer
   import icu_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   icu_if.issuer            link,
   input  wire logic        req,
   input  wire logic [2:0]  req_kind,
   input  wire logic        req_unsigned,
   input  wire logic        req_imm,
   input  wire logic [4:0]  req_a,
   input  wire logic [4:0]  req_b,
   input  wire logic [4:0]  req_dst,
   input  wire logic [15:0] req_const,
   input  wire logic [4:0]  rd_idx,
   output logic             ready,
   output logic [31:0]      rd_data,
   output logic             done
);
   // Kinds: 0 eq, 1 ge, 2 gt, 3 le; immediate gt/le take const+1.
   logic [31:0] regs_reg [ICU_NREGS];
   logic [31:0] regs_next [ICU_NREGS];
   logic        issue_reg, issue_next;
   logic [31:0] instr_reg, instr_next;
   logic [31:0] sa_reg, sa_next, sb_reg, sb_next;
   logic        busy_reg, busy_next;
   logic        done_reg, done_next;
   logic [31:0] rd_reg, rd_next;
   logic        ready_reg, ready_next;
   logic [4:0]  fa, fb;
   logic [15:0] k;
   logic [5:0]  op;
   logic [5:0]  xop;

   // ----------------------------------------------------------------
   // Encoding and register file.
   // ----------------------------------------------------------------
   always_comb begin
      fa  = req_a;
      fb  = req_b;
      k   = req_const;
      op  = ICU_OP_RTYPE;
      xop = ICU_XOP_CMPEQ;
      if (!req_imm && (req_kind == 3'h2 || req_kind == 3'h3)) begin
         fa = req_b; // RQ10 RQ11
         fb = req_a;
      end
      if (req_imm && (req_kind == 3'h2 || req_kind == 3'h3)) begin
         k = req_const + 16'h0001; // RQ12 RQ13
      end
      // Greater-than swaps into less-than, which the unit leaves to others;
      // here only ge-based forms are emitted, so register gt swaps into ge, the same as le.
      if (req_imm) begin
         op = (req_kind == 3'h0) ? ICU_OP_CMPEQI :
              (req_unsigned ? ICU_OP_CMPGEUI : ICU_OP_CMPGEI);
      end else begin
         xop = (req_kind == 3'h0) ? ICU_XOP_CMPEQ :
               (req_unsigned ? ICU_XOP_CMPGEU : ICU_XOP_CMPGE);
      end
      issue_next = 1'b0;
      instr_next = instr_reg;
      sa_next    = sa_reg;
      sb_next    = sb_reg;
      busy_next  = busy_reg;
      done_next  = 1'b0;
      regs_next  = regs_reg;
      rd_next    = regs_reg[rd_idx];
      if (req && !busy_reg) begin
         issue_next = 1'b1;
         busy_next  = 1'b1;
         sa_next    = regs_reg[fa];
         sb_next    = regs_reg[fb];
         if (req_imm) begin
            instr_next = {fa, req_dst, k, op};
         end else begin
            instr_next = {fa, fb, req_dst, xop, 5'h00, op};
         end
      end
      if (link.wr_en) begin
         busy_next = 1'b0;
         done_next = 1'b1;
         if (link.wr_idx != ICU_ZERO_REG) begin
            regs_next[link.wr_idx] = link.wr_data;
         end
      end
      ready_next = !busy_next;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         issue_reg <= 1'b0;
         instr_reg <= ICU_WORD_RESET;
         sa_reg    <= ICU_WORD_RESET;
         sb_reg    <= ICU_WORD_RESET;
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
         rd_reg    <= ICU_WORD_RESET;
         ready_reg <= 1'b1;
         for (int i = 0; i < ICU_NREGS; i++) begin
            regs_reg[i] <= ICU_WORD_RESET;
         end
      end else begin
         issue_reg <= issue_next;
         instr_reg <= instr_next;
         sa_reg    <= sa_next;
         sb_reg    <= sb_next;
         busy_reg  <= busy_next;
         done_reg  <= done_next;
         rd_reg    <= rd_next;
         ready_reg <= ready_next;
         regs_reg  <= regs_next;
      end
   end

   assign link.issue = issue_reg;
   assign link.instr = instr_reg;
   assign link.src_a = sa_reg;
   assign link.src_b = sb_reg;
   assign ready      = ready_reg;
   assign rd_data    = rd_reg;
   assign done       = done_reg;
endmodule

/* rtl/icu_unit.sv */
// Purpose: Integer compare unit executing equal and not-less compares.
// Assumes: Operands are already read from fields A and B by the issuer.
// Notes:   Result is registered; latency is one cycle from issue.
//
// Function
// (RQ1) Register equal compare writes 1 else 0.
// (RQ2) Equal against zero register gives logical negation.
// (RQ3) Immediate equal, opcode 0x20, writes field B.
// (RQ4) Signed immediates sign-extend sixteen to thirty-two bits.
// (RQ5) Register signed ge, extended opcode 0x08.
// (RQ6) Immediate signed ge, opcode 0x08, field B.
// (RQ7) Register unsigned ge writes field C.
// (RQ8) Unsigned immediates zero-extend upper half.
// (RQ9) Immediate unsigned ge, opcode 0x28, field B.
// (RQ10) Greater-than register forms swap into less-than; the issuer emits swapped ge instead.
// (RQ11) Less-or-equal register forms swap into ge.
// (RQ12) Signed immediate gt/le use immediate plus one.
// (RQ13) Unsigned immediate gt/le use immediate plus one.
// (RQ14) Register forms read A, B; write C.
// (RQ15) Immediate forms take constant, write field B.
// (RQ16) No exceptions; result zero-extended to 32 bits.
// (RQ17) Fixed field positions for A, B, C, opcodes.
`timescale 1ns/1ps
module icu_unit
   import icu_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset_n,
   icu_if.unit       link
);
   logic [5:0]  op;
   logic [5:0]  xop;
   logic [4:0]  fb;
   logic [4:0]  fc;
   logic [15:0] imm;
   logic [31:0] sext;
   logic [31:0] zext;
   logic        res;
   logic        hit;
   logic [4:0]  dst;
   logic        wr_en_reg, wr_en_next;
   logic [4:0]  wr_idx_reg, wr_idx_next;
   logic [31:0] wr_data_reg, wr_data_next;
   logic        ill_reg, ill_next;

   // ----------------------------------------------------------------
   // Decode and compare.
   // ----------------------------------------------------------------
   always_comb begin
      op   = link.instr[ICU_OP_LSB +: ICU_OP_W]; // RQ17
      xop  = link.instr[ICU_XOP_LSB +: ICU_OP_W]; // RQ17
      fb   = link.instr[ICU_B_LSB +: ICU_IDX_W]; // RQ17
      fc   = link.instr[ICU_C_LSB +: ICU_IDX_W]; // RQ17
      imm  = link.instr[ICU_IMM_LSB +: ICU_IMM_W]; // RQ17
      sext = {{16{imm[15]}}, imm}; // RQ4
      zext = {ICU_ZEXT_UPPER, imm}; // RQ8
      res  = 1'b0;
      hit  = 1'b1;
      dst  = fb; // RQ15
      case (op)
         ICU_OP_RTYPE: begin
            dst = fc; // RQ14
            case (xop)
               ICU_XOP_CMPEQ:  res = (link.src_a == link.src_b); // RQ1 RQ2
               ICU_XOP_CMPGE:  res = ($signed(link.src_a) >= $signed(link.src_b)); // RQ5
               ICU_XOP_CMPGEU: res = (link.src_a >= link.src_b); // RQ7
               default:        hit = 1'b0;
            endcase
         end
         ICU_OP_CMPEQI:  res = (link.src_a == sext); // RQ3
         ICU_OP_CMPGEI:  res = ($signed(link.src_a) >= $signed(sext)); // RQ6
         ICU_OP_CMPGEUI: res = (link.src_a >= zext); // RQ9
         default:        hit = 1'b0;
      endcase
      wr_en_next   = link.issue && hit;
      wr_idx_next  = (link.issue && hit) ? dst : wr_idx_reg;
      wr_data_next = (link.issue && hit) ? {31'h0, res} : wr_data_reg; // RQ16
      ill_next     = link.issue && !hit;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_en_reg   <= 1'b0;
         wr_idx_reg  <= ICU_ZERO_REG;
         wr_data_reg <= ICU_WORD_RESET;
         ill_reg     <= 1'b0;
      end else begin
         wr_en_reg   <= wr_en_next;
         wr_idx_reg  <= wr_idx_next;
         wr_data_reg <= wr_data_next;
         ill_reg     <= ill_next;
      end
   end

   assign link.wr_en   = wr_en_reg;
   assign link.wr_idx  = wr_idx_reg;
   assign link.wr_data = wr_data_reg;
   assign link.illegal = ill_reg;
endmodule

/* tb/icu_sva.sv */
// Purpose: Assertions on the compare link.
// Assumes: One clock; reset_n low resets.
// Notes:   Results land one cycle after issue.
`timescale 1ns/1ps
module icu_sva
   import icu_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        issue,
   input wire logic [31:0] instr,
   input wire logic [31:0] src_a,
   input wire logic [31:0] src_b,
   input wire logic        wr_en,
   input wire logic [4:0]  wr_idx,
   input wire logic [31:0] wr_data,
   input wire logic        illegal
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire [5:0]  op = instr[5:0];
   wire [5:0]  xop = instr[16:11];
   wire        rt = issue && op == ICU_OP_RTYPE;
   wire [31:0] sx = {{16{instr[21]}}, instr[21:6]};
   wire [31:0] zx = {ICU_ZEXT_UPPER, instr[21:6]};
   wire        rl = rt && (xop == ICU_XOP_CMPEQ || xop == ICU_XOP_CMPGE || xop == ICU_XOP_CMPGEU);
   wire        il = issue && (op == ICU_OP_CMPEQI || op == ICU_OP_CMPGEI || op == ICU_OP_CMPGEUI);
   AST_EQ_REG: assert property (rt && xop == ICU_XOP_CMPEQ |=> wr_en &&
      wr_data == {31'h0, ($past(src_a) == $past(src_b))}) else $error("eq result wrong");
   AST_EQ_IMM: assert property (issue && op == ICU_OP_CMPEQI |=> wr_en &&
      wr_data == {31'h0, ($past(src_a) == $past(sx))}) else $error("eqi result wrong");
   AST_GE_REG: assert property (rt && xop == ICU_XOP_CMPGE |=> wr_data ==
      {31'h0, ($signed($past(src_a)) >= $signed($past(src_b)))}) else $error("ge wrong");
   AST_GE_IMM: assert property (issue && op == ICU_OP_CMPGEI |=> wr_data ==
      {31'h0, ($signed($past(src_a)) >= $signed($past(sx)))}) else $error("gei wrong");
   AST_GEU_REG: assert property (rt && xop == ICU_XOP_CMPGEU |=> wr_data ==
      {31'h0, ($past(src_a) >= $past(src_b))}) else $error("geu wrong");
   AST_GEU_IMM: assert property (issue && op == ICU_OP_CMPGEUI |=> wr_data ==
      {31'h0, ($past(src_a) >= $past(zx))}) else $error("geui wrong");
   AST_DST_REG: assert property (rl |=> wr_idx == $past(instr[21:17]))
      else $error("reg destination wrong");
   AST_DST_IMM: assert property (il |=> wr_idx == $past(instr[26:22]))
      else $error("imm destination wrong");
   AST_NO_EXC: assert property (rl || il |=> wr_en && !illegal)
      else $error("compare raised a fault");
   AST_ZEXT: assert property (wr_en |-> $past(issue) && wr_data[31:1] == 31'h0)
      else $error("result not zero-extended");
   AST_ILL_NO_WR: assert property (illegal |-> !wr_en)
      else $error("illegal word wrote a result");
   AST_WR_PULSE: assert property (wr_en |=> !wr_en)
      else $error("write strobe stood too long");
   C_REG: cover property (rl);
   C_IMM: cover property (il);
   C_ONE: cover property (wr_en && wr_data[0]);
endmodule

/* tb/integer_compare_unit_tb.sv */
// Purpose: Random and corner compares through issuer and unit.
// Assumes: Register file starts at zero.
// Notes:   Bench mirrors the register file.
`timescale 1ns/1ps
module integer_compare_unit_tb
   import icu_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        req = 1'b0;
   logic        uns = 1'b0;
   logic        imm = 1'b0;
   logic [2:0]  kind = 3'h0;
   logic [4:0]  ra = 5'h00, rb = 5'h00, rd = 5'h00, ri = 5'h00;
   logic [15:0] k = 16'h0000;
   logic [31:0] r;
   logic [31:0] regs [32] = '{default: 32'h0};
   wire         ready, done;
   wire  [31:0] rd_data;
   int          seed = 47, n_mismatch = 0, compares = 0;
   always #50 clk = ~clk;
   icu_if link();
   icu_unit u_icu_unit(.clk(clk), .reset_n(reset_n), .link(link.unit));
   icu_issuer u_icu_issuer(.clk(clk), .reset_n(reset_n), .link(link.issuer), .req(req),
      .req_kind(kind), .req_unsigned(uns), .req_imm(imm), .req_a(ra), .req_b(rb),
      .req_dst(rd), .req_const(k), .rd_idx(ri), .ready(ready), .rd_data(rd_data), .done(done));
   icu_sva u_icu_sva(.clk(clk), .reset_n(reset_n), .issue(link.issue), .instr(link.instr),
      .src_a(link.src_a), .src_b(link.src_b), .wr_en(link.wr_en), .wr_idx(link.wr_idx),
      .wr_data(link.wr_data), .illegal(link.illegal));
   function automatic logic [31:0] model(logic [2:0] kd, logic u, logic i,
                                         logic [31:0] a, logic [31:0] b, logic [15:0] c);
      logic [31:0] x;
      x = i ? {(u ? ICU_ZEXT_UPPER : {16{c[15]}}), c} : b;
      if (!i && kd[1]) begin
         x = a;
         a = b;
      end
      if (kd == 3'h0) return {31'h0, (a == x)};
      if (i && kd == 3'h2) return {31'h0, (u ? (a > x) : ($signed(a) > $signed(x)))};
      if (u) return {31'h0, (a >= x)};
      return {31'h0, ($signed(a) >= $signed(x))};
   endfunction
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(logic [31:0] got, logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic run(logic [2:0] kd, logic u, logic i, logic [4:0] a, logic [4:0] b,
                      logic [4:0] d, logic [15:0] c);
      logic [31:0] e;
      int          t;
      if (kd == 3'h0) u = 1'b0;
      if (kd == 3'h3) i = 1'b0;
      if (kd == 3'h2 && i && c == (u ? 16'hFFFF : 16'h7FFF)) c = 16'h0000;
      e = model(kd, u, i, regs[a], regs[b], c);
      @(negedge clk);
      {req, kind, uns, imm, ra, rb, rd, k} = {1'b1, kd, u, i, a, b, d, c};
      @(negedge clk);
      req = 1'b0;
      check({31'h0, ready}, 32'h0);
      @(negedge clk);
      check({30'h0, link.wr_en, link.illegal}, 32'h2);
      check({27'h0, link.wr_idx}, {27'h0, d});
      for (t = 0; t < 10 && done !== 1'b1; t++) @(negedge clk);
      if (t == 10) begin
         n_mismatch++;
         stop_test();
      end else begin
         check(link.wr_data, e);
         check({31'h0, ready}, 32'h1);
         if (d != 5'h00) regs[d] = e;
         ri = d;
         repeat (2) @(negedge clk);
         check(rd_data, regs[d]);
      end
   endtask
   initial begin
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      run(3'h0, 1'b0, 1'b0, 5'h00, 5'h00, 5'h01, 16'h0000);
      run(3'h0, 1'b0, 1'b0, 5'h01, 5'h00, 5'h02, 16'h0000);
      run(3'h0, 1'b0, 1'b1, 5'h01, 5'h00, 5'h03, 16'hFFFF);
      run(3'h1, 1'b0, 1'b1, 5'h00, 5'h00, 5'h04, 16'hFFFF);
      run(3'h1, 1'b1, 1'b1, 5'h00, 5'h00, 5'h05, 16'hFFFF);
      run(3'h1, 1'b0, 1'b0, 5'h02, 5'h01, 5'h06, 16'h0000);
      run(3'h1, 1'b1, 1'b0, 5'h01, 5'h02, 5'h07, 16'h0000);
      run(3'h2, 1'b1, 1'b1, 5'h01, 5'h00, 5'h08, 16'h0000);
      run(3'h3, 1'b0, 1'b0, 5'h01, 5'h02, 5'h09, 16'h0000);
      run(3'h2, 1'b0, 1'b1, 5'h01, 5'h00, 5'h0A, 16'hFFFF);
      @(negedge clk);
      reset_n = 1'b0;
      #1;
      check(link.wr_data, ICU_WORD_RESET);
      check(rd_data, ICU_WORD_RESET);
      regs = '{default: 32'h0};
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      repeat (80) begin
         r = $random(seed);
         run({1'b0, r[1:0]}, r[2], r[3], r[8:4], r[13:9], r[18:14], r[31:16]);
      end
      stop_test();
   end
endmodule
